// ---- lpfc_consts.vh ----
// Constants for the line printer forms control block
`ifndef LPFC_CONSTS_VH
`define LPFC_CONSTS_VH
// -----------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------
`define LPFC_A_CMD 8'h00
`define LPFC_A_LOAD 8'h04
`define LPFC_A_PRINT 8'h08
`define LPFC_A_STAT 8'h0c
`define LPFC_A_IRQS 8'h10
`define LPFC_A_IRQM 8'h14
`define LPFC_A_SNS_LO 8'h20
`define LPFC_A_SNS_HI 8'h34
// -----------------------------------------------------------
// Command codes, CMD bits [3:0], argument bits [7:4]
// -----------------------------------------------------------
`define LPFC_C_SPACE 4'h1
`define LPFC_C_SKIP 4'h2
`define LPFC_C_LOAD_BEGIN 4'h3
`define LPFC_C_LOAD_END 4'h4
`define LPFC_C_PRINT 4'h5
`define LPFC_C_SENSE_CLR 4'h6
`define LPFC_C_INDEX 4'h7
// -----------------------------------------------------------
// Buffer load byte and entry layout
// -----------------------------------------------------------
`define LPFC_E_EOF 4
`define LPFC_E_DENS 5
`define LPFC_E_RSVD 6
`define LPFC_E_INDEX 7
`define LPFC_MAX_CODE 4'hc
`define LPFC_NO_CODE 4'h0
// -----------------------------------------------------------
// Sense bits, byte 0 and byte 1
// -----------------------------------------------------------
`define LPFC_S0_CMDREJ 7
`define LPFC_S0_EQUIP 4
`define LPFC_S0_DATACHK 3
`define LPFC_S1_NOEOF 3
`define LPFC_S1_BADCODE 2
`define LPFC_S1_LINEOVF 1
// -----------------------------------------------------------
// Interrupt bits and status fields
// -----------------------------------------------------------
`define LPFC_I_DONE 0
`define LPFC_I_LOADERR 1
`define LPFC_I_RUNAWAY 2
`define LPFC_I_CHECK 3
`define LPFC_I_W 4
`define LPFC_ST_BUSY 0
`define LPFC_ST_LOADING 1
`define LPFC_ST_DENS 2
`define LPFC_ST_INHIBIT 3
`define LPFC_ST_POS 8
`endif

// ---- lpfc_sync.v ----
// Three-stage synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module lpfc_sync (
   input wire sys_clk,
   input wire srst,
   input wire pin_in,
   output reg level_out
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   // Change accepted only when stages two and three agree
   always @(posedge sys_clk) begin
      if (srst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_out <= 1'b0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_out <= s3_r;
         end
      end
   end
endmodule // lpfc_sync
`default_nettype wire

// ---- lpfc_fcb_mem.v ----
// Forms control buffer storage, one entry per print line
`timescale 1ns/1ps
`default_nettype none
module lpfc_fcb_mem #(
   parameter DEPTH = 192,
   parameter AW = 8,
   parameter DW = 6
) (
   input wire sys_clk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire [AW-1:0] raddr,
   output wire [DW-1:0] rdata
);
   reg [DW-1:0] mem_r [0:DEPTH-1];
   // Contents undefined until loaded; host must load first
   always @(posedge sys_clk) begin
      if (we) begin
         mem_r[waddr] <= wdata;
      end
   end
   assign rdata = mem_r[raddr];
endmodule // lpfc_fcb_mem
`default_nettype wire

// ---- lpfc_top.v ----
// Forms control top: APB registers, buffer load, carriage stepping
`timescale 1ns/1ps
`default_nettype none
`include "lpfc_consts.vh"
module lpfc_top #(
   parameter DEPTH = 192,
   parameter LINE_W = 132
) (
   input wire sys_clk,
   input wire srst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire feed_done_pin,
   output reg feed_step,
   output reg print_strobe,
   output reg density_8lpi,
   output reg motion_inhibit,
   output reg irq
);
   // -----------------------------------------------------------
   // State codes
   // -----------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_STEP = 2'd1;
   localparam [1:0] ST_WAIT = 2'd2;
   localparam [1:0] ST_CHECK = 2'd3;
   localparam [31:0] DEPTH_W = DEPTH;
   localparam [31:0] LINE_W_W = LINE_W;
   localparam [7:0] LAST_POS = DEPTH_W[7:0] - 8'h01;
   localparam [7:0] LINE_MAX = LINE_W_W[7:0];

   // -----------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------
   reg [1:0] state_r;
   reg [7:0] pos_r;
   reg [3:0] remain_r;
   reg skip_r;
   reg [3:0] target_r;
   reg [1:0] pass_r;
   reg loading_r;
   reg [7:0] load_cnt_r;
   reg [7:0] load_idx_r;
   reg seen_eof_r;
   reg bad_code_r;
   reg [7:0] col_r;
   reg [7:0] sns0_r;
   reg [7:0] sns1_r;
   reg [`LPFC_I_W-1:0] irq_stat_r;
   reg [`LPFC_I_W-1:0] irq_mask_r;
   reg done_d_r;
   wire feed_done;
   wire done_rise;
   wire [5:0] entry;
   reg mem_we;
   reg [5:0] mem_wdata;
   wire acc;
   wire wr_en;
   wire [7:0] wbyte;
   wire [3:0] cmd;
   wire [3:0] arg;
   wire busy;
   reg [`LPFC_I_W-1:0] ev_r;

   // -----------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------
   function valid_code;
      input [7:0] b;
      begin
         valid_code = !b[`LPFC_E_INDEX] && !b[`LPFC_E_RSVD] &&
            (b[3:0] <= `LPFC_MAX_CODE);
      end
   endfunction

   function [7:0] wrap_pos;
      input [7:0] p;
      input eof;
      begin
         if (eof || p == LAST_POS) begin
            wrap_pos = 8'h00;
         end else begin
            wrap_pos = p + 8'h01;
         end
      end
   endfunction

   function [31:0] sense_word;
      input [2:0] idx;
      input [7:0] s0;
      input [7:0] s1;
      input [7:0] s2;
      input [7:0] s3;
      input [7:0] s4;
      begin
         if (idx == 3'd0) begin
            sense_word = {s3, s2, s1, s0};
         end else if (idx == 3'd1) begin
            sense_word = {24'h000000, s4};
         end else begin
            sense_word = 32'h00000000;
         end
      end
   endfunction

   // -----------------------------------------------------------
   // Pin input and buffer storage
   // -----------------------------------------------------------
   lpfc_sync u_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .pin_in(feed_done_pin),
      .level_out(feed_done)
   );

   lpfc_fcb_mem #(
      .DEPTH(DEPTH),
      .AW(8),
      .DW(6)
   ) u_mem (
      .sys_clk(sys_clk),
      .we(mem_we),
      .waddr(load_idx_r),
      .wdata(mem_wdata),
      .raddr(pos_r),
      .rdata(entry)
   );

   assign done_rise = feed_done && !done_d_r;
   assign acc = psel && penable && pready;
   assign wr_en = acc && pwrite;
   assign wbyte = pwdata[7:0];
   assign cmd = pwdata[3:0];
   assign arg = pwdata[7:4];
   assign busy = (state_r != ST_IDLE);

   // -----------------------------------------------------------
   // Buffer write path
   // -----------------------------------------------------------
   always @* begin
      mem_we = 1'b0;
      mem_wdata = {wbyte[`LPFC_E_DENS], wbyte[`LPFC_E_EOF], wbyte[3:0]};
      // Leading indexing byte is dropped, so byte 2 is line 1
      if (wr_en && paddr == `LPFC_A_LOAD && loading_r &&
          !(load_cnt_r == 8'h00 && wbyte[`LPFC_E_INDEX]) &&
          load_idx_r <= LAST_POS) begin
         mem_we = 1'b1;
      end
   end

   // -----------------------------------------------------------
   // APB slave, one wait-free access after setup
   // -----------------------------------------------------------
   always @(posedge sys_clk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (paddr == `LPFC_A_STAT) begin
            prdata <= {16'h0000, pos_r, 4'h0, motion_inhibit,
               density_8lpi, loading_r, busy};
         end else if (paddr == `LPFC_A_IRQS) begin
            prdata <= {28'h0000000, irq_stat_r};
         end else if (paddr == `LPFC_A_IRQM) begin
            prdata <= {28'h0000000, irq_mask_r};
         end else if (paddr >= `LPFC_A_SNS_LO &&
                      paddr <= `LPFC_A_SNS_HI && paddr[1:0] == 2'b00) begin
            // Five sense bytes in the first two of six words, the rest read zero
            prdata <= sense_word(paddr[4:2], sns0_r, sns1_r, pos_r,
               {4'h0, target_r}, load_cnt_r);
         end else if (paddr == `LPFC_A_CMD || paddr == `LPFC_A_LOAD ||
                      paddr == `LPFC_A_PRINT) begin
            prdata <= 32'h00000000;
         end else begin
            pslverr <= 1'b1;
         end
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // -----------------------------------------------------------
   // Control, carriage stepping and sense
   // -----------------------------------------------------------
   always @(posedge sys_clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
         pos_r <= 8'h00;
         remain_r <= 4'h0;
         skip_r <= 1'b0;
         target_r <= 4'h0;
         pass_r <= 2'd0;
         loading_r <= 1'b0;
         load_cnt_r <= 8'h00;
         load_idx_r <= 8'h00;
         seen_eof_r <= 1'b0;
         bad_code_r <= 1'b0;
         col_r <= 8'h00;
         sns0_r <= 8'h00;
         sns1_r <= 8'h00;
         done_d_r <= 1'b0;
         feed_step <= 1'b0;
         print_strobe <= 1'b0;
         density_8lpi <= 1'b0;
         motion_inhibit <= 1'b0;
         ev_r <= {`LPFC_I_W{1'b0}};
      end else begin
         // Events reach status one cycle later, irq one more
         ev_r <= {`LPFC_I_W{1'b0}};
         done_d_r <= feed_done;
         feed_step <= 1'b0;
         print_strobe <= 1'b0;
         // Clear first so a same-cycle check below wins
         if (wr_en && paddr == `LPFC_A_CMD &&
             cmd == `LPFC_C_SENSE_CLR) begin
            sns0_r <= 8'h00;
            sns1_r <= 8'h00;
            motion_inhibit <= 1'b0;
         end
         if (wr_en && paddr == `LPFC_A_CMD &&
             cmd != `LPFC_C_SENSE_CLR) begin
            if (busy || cmd == `LPFC_C_INDEX ||
                (loading_r && cmd != `LPFC_C_LOAD_END)) begin
               // Indexing and overlapping commands refused
               sns0_r[`LPFC_S0_CMDREJ] <= 1'b1;
               ev_r[`LPFC_I_CHECK] <= 1'b1;
            end else if (cmd == `LPFC_C_SPACE ||
                         cmd == `LPFC_C_PRINT) begin
               if (cmd == `LPFC_C_PRINT) begin
                  print_strobe <= 1'b1;
                  col_r <= 8'h00;
               end
               if (motion_inhibit || arg == 4'h0) begin
                  // Held form lets the host retry the same line
                  ev_r[`LPFC_I_DONE] <= 1'b1;
               end else begin
                  remain_r <= arg;
                  skip_r <= 1'b0;
                  state_r <= ST_STEP;
               end
            end else if (cmd == `LPFC_C_SKIP) begin
               if (arg == `LPFC_NO_CODE || arg > `LPFC_MAX_CODE) begin
                  sns0_r[`LPFC_S0_CMDREJ] <= 1'b1;
                  ev_r[`LPFC_I_CHECK] <= 1'b1;
               end else if (motion_inhibit) begin
                  ev_r[`LPFC_I_DONE] <= 1'b1;
               end else begin
                  target_r <= arg;
                  skip_r <= 1'b1;
                  pass_r <= 2'd0;
                  state_r <= ST_STEP;
               end
            end else if (cmd == `LPFC_C_LOAD_BEGIN) begin
               // Host fills the buffer before skipping
               loading_r <= 1'b1;
               load_cnt_r <= 8'h00;
               load_idx_r <= 8'h00;
               seen_eof_r <= 1'b0;
               bad_code_r <= 1'b0;
               pos_r <= 8'h00;
            end else if (cmd == `LPFC_C_LOAD_END) begin
               loading_r <= 1'b0;
               if (!seen_eof_r || bad_code_r) begin
                  // Missing end-of-form or bad code
                  sns1_r[`LPFC_S1_NOEOF] <= !seen_eof_r;
                  sns1_r[`LPFC_S1_BADCODE] <= bad_code_r;
                  ev_r[`LPFC_I_LOADERR] <= 1'b1;
               end else begin
                  ev_r[`LPFC_I_DONE] <= 1'b1;
               end
            end else begin
               sns0_r[`LPFC_S0_CMDREJ] <= 1'b1;
               ev_r[`LPFC_I_CHECK] <= 1'b1;
            end
         end
         // Buffer load stream
         if (wr_en && paddr == `LPFC_A_LOAD) begin
            if (!loading_r) begin
               sns0_r[`LPFC_S0_CMDREJ] <= 1'b1;
               ev_r[`LPFC_I_CHECK] <= 1'b1;
            end else begin
               load_cnt_r <= load_cnt_r + 8'h01;
               if (!(load_cnt_r == 8'h00 && wbyte[`LPFC_E_INDEX])) begin
                  if (load_idx_r > LAST_POS) begin
                     bad_code_r <= 1'b1;
                  end else begin
                     load_idx_r <= load_idx_r + 8'h01;
                     if (!valid_code(wbyte)) begin
                        bad_code_r <= 1'b1;
                     end
                     if (wbyte[`LPFC_E_EOF]) begin
                        seen_eof_r <= 1'b1;
                     end
                     if (load_idx_r == 8'h00) begin
                        density_8lpi <= wbyte[`LPFC_E_DENS];
                     end
                  end
               end
            end
         end
         // Print line data with odd parity in bit 8
         if (wr_en && paddr == `LPFC_A_PRINT) begin
            if (col_r >= LINE_MAX) begin
               sns1_r[`LPFC_S1_LINEOVF] <= 1'b1;
               sns0_r[`LPFC_S0_CMDREJ] <= 1'b1;
               ev_r[`LPFC_I_CHECK] <= 1'b1;
            end else begin
               col_r <= col_r + 8'h01;
            end
            if (!(^pwdata[8:0])) begin
               sns0_r[`LPFC_S0_DATACHK] <= 1'b1;
               motion_inhibit <= 1'b1;
               ev_r[`LPFC_I_CHECK] <= 1'b1;
            end
         end
         // Carriage sequencer
         case (state_r)
            ST_STEP: begin
               feed_step <= 1'b1;
               state_r <= ST_WAIT;
            end
            ST_WAIT: begin
               if (done_rise) begin
                  pos_r <= wrap_pos(pos_r, entry[`LPFC_E_EOF]);
                  state_r <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               if (skip_r) begin
                  if (entry[3:0] == target_r) begin
                     state_r <= ST_IDLE;
                     ev_r[`LPFC_I_DONE] <= 1'b1;
                  end else if (pos_r == 8'h00 && pass_r == 2'd1) begin
                     // Runaway stop on second arrival at line 1
                     state_r <= ST_IDLE;
                     sns0_r[`LPFC_S0_EQUIP] <= 1'b1;
                     ev_r[`LPFC_I_RUNAWAY] <= 1'b1;
                  end else begin
                     if (pos_r == 8'h00) begin
                        pass_r <= pass_r + 2'd1;
                     end
                     state_r <= ST_STEP;
                  end
               end else if (remain_r == 4'h1) begin
                  state_r <= ST_IDLE;
                  ev_r[`LPFC_I_DONE] <= 1'b1;
               end else begin
                  remain_r <= remain_r - 4'h1;
                  state_r <= ST_STEP;
               end
            end
            default: begin
               // Idle keeps what the command decode above chose
            end
         endcase
      end
   end

   // -----------------------------------------------------------
   // Interrupt status and mask
   // -----------------------------------------------------------
   always @(posedge sys_clk) begin
      if (srst) begin
         irq_stat_r <= {`LPFC_I_W{1'b0}};
         irq_mask_r <= {`LPFC_I_W{1'b0}};
         irq <= 1'b0;
      end else begin
         // Event set wins over write-one clear
         irq_stat_r <= (irq_stat_r & ~((wr_en && paddr == `LPFC_A_IRQS) ?
            pwdata[`LPFC_I_W-1:0] : {`LPFC_I_W{1'b0}})) | ev_r;
         if (wr_en && paddr == `LPFC_A_IRQM) begin
            irq_mask_r <= pwdata[`LPFC_I_W-1:0];
         end
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end
endmodule // lpfc_top
`default_nettype wire

// ---- lpfc_paper_drive.sv ----
// Paper drive model answering each feed step with one line done
`timescale 1ns/1ps
`default_nettype none
module lpfc_paper_drive (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic feed_step,
   input wire logic [7:0] lag,
   output logic feed_done_pin
);
   logic [7:0] cnt_r;
   logic [1:0] st_r;
   // Pin falls between lines so that every line gives a fresh edge
   always @(posedge sys_clk) begin
      if (srst) begin
         st_r <= 2'h0;
         cnt_r <= 8'h00;
         feed_done_pin <= 1'b0;
      end else if (feed_step) begin
         st_r <= 2'h1;
         cnt_r <= lag;
      end else if (st_r != 2'h0 && cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end else if (st_r == 2'h1) begin
         st_r <= 2'h2;
         cnt_r <= 8'h01;
         feed_done_pin <= 1'b1;
      end else if (st_r == 2'h2) begin
         st_r <= 2'h0;
         feed_done_pin <= 1'b0;
      end
   end
endmodule // lpfc_paper_drive
`default_nettype wire

// ---- lpfc_top_monitor.sv ----
// Port checker for the forms control top
`timescale 1ns/1ps
`default_nettype none
`include "lpfc_consts.vh"
module lpfc_top_monitor #(
   parameter DEPTH = 192,
   parameter LINE_W = 132
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic feed_done_pin,
   input wire logic feed_step,
   input wire logic print_strobe,
   input wire logic density_8lpi,
   input wire logic motion_inhibit,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   wire logic cmd_wr;
   wire logic [3:0] op;
   assign cmd_wr = psel && penable && pready && pwrite
      && paddr == `LPFC_A_CMD;
   assign op = pwdata[3:0];
   a_ready_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_once: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_step_start: assert property (
      cmd_wr && op == `LPFC_C_SPACE && pwdata[7:4] != 4'h0
      && !motion_inhibit |-> ##[1:3] feed_step)
      else $error("space gave no feed step");
   a_step_gap: assert property (
      feed_step |=> !feed_step [*4])
      else $error("feed steps too close");
   a_motion_stop: assert property (
      motion_inhibit |-> !feed_step)
      else $error("feed step while inhibited");
   a_inhibit_hold: assert property (
      motion_inhibit && !(cmd_wr && op == `LPFC_C_SENSE_CLR)
      |=> motion_inhibit)
      else $error("inhibit dropped without clear");
   a_print_go: assert property (
      cmd_wr && op == `LPFC_C_PRINT && !motion_inhibit
      |-> ##[1:3] print_strobe)
      else $error("print gave no strobe");
endmodule // lpfc_top_monitor
bind lpfc_top lpfc_top_monitor #(.DEPTH(DEPTH), .LINE_W(LINE_W)) i_mon (
   .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .feed_done_pin(feed_done_pin),
   .feed_step(feed_step), .print_strobe(print_strobe),
   .density_8lpi(density_8lpi), .motion_inhibit(motion_inhibit),
   .irq(irq));
`default_nettype wire

// ---- lpfc_top_tb_top.sv ----
// Self-checking bench for the forms control top
`timescale 1ns/1ps
`default_nettype none
`include "lpfc_consts.vh"
module lpfc_top_tb_top;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] lag = 8'h00;
   logic [31:0] prdata;
   logic pready, pslverr, feed_done_pin, feed_step, print_strobe;
   logic density_8lpi, motion_inhibit, irq, serr;
   logic [31:0] rd;
   logic [7:0] fq[$];
   int err_count = 0;
   int total_checks = 0;
   int steps = 0;
   int strobes = 0;

   lpfc_top #(.DEPTH(192), .LINE_W(132)) i_dut (
      .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .feed_done_pin(feed_done_pin),
      .feed_step(feed_step), .print_strobe(print_strobe),
      .density_8lpi(density_8lpi), .motion_inhibit(motion_inhibit),
      .irq(irq));
   lpfc_paper_drive i_drv (.sys_clk(sys_clk), .srst(srst),
      .feed_step(feed_step), .lag(lag), .feed_done_pin(feed_done_pin));

   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (feed_step === 1'b1)
         steps <= steps + 1;
      if (print_strobe === 1'b1)
         strobes <= strobes + 1;
   end

   task conclude;
      $display("Checks made %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Held until pready is seen high, released only after that edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge sys_clk);
      // No limit here; only the watchdog ends a stuck access
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
         n++;
      end
      rd = prdata;
      serr = pslverr;
      chk("apb wait states", 32'h0, n);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task cmd(input logic [3:0] c, input logic [3:0] arg);
      int n;
      apb(1'b1, `LPFC_A_CMD, {24'h0, arg, c});
      n = 0;
      do begin
         apb(1'b0, `LPFC_A_STAT, 32'h0);
         n++;
      end while (rd[`LPFC_ST_BUSY] !== 1'b0 && n < 500);
      chk("busy", 32'h0, rd[`LPFC_ST_BUSY]);
   endtask

   task load_form;
      cmd(`LPFC_C_LOAD_BEGIN, 4'h0);
      foreach (fq[i])
         apb(1'b1, `LPFC_A_LOAD, {24'h0, fq[i]});
      cmd(`LPFC_C_LOAD_END, 4'h0);
      apb(1'b0, `LPFC_A_SNS_LO, 32'h0);
   endtask

   task clr;
      cmd(`LPFC_C_SENSE_CLR, 4'h0);
      apb(1'b1, `LPFC_A_IRQS, 32'hf);
   endtask

   task t_regs;
      apb(1'b0, `LPFC_A_IRQM, 32'h0);
      chk("irq mask reset", 32'h0, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped pslverr", 32'h1, serr);
      apb(1'b0, `LPFC_A_SNS_HI, 32'h0);
      chk("last sense word", 32'h0, rd);
      apb(1'b1, `LPFC_A_IRQM, 32'ha);
      apb(1'b0, `LPFC_A_IRQM, 32'h0);
      chk("irq mask", 32'ha, rd);
      apb(1'b1, `LPFC_A_LOAD, 32'h1);
      apb(1'b0, `LPFC_A_SNS_LO, 32'h0);
      chk("stray load reject", 32'h80, rd & 32'hff);
      clr();
   endtask

   task t_loaderr(input logic [7:0] b0, input logic [7:0] b1, input int bn);
      fq = '{b0, b1};
      load_form();
      chk("load sense", 32'h1 << bn, rd & 32'hff00);
      chk("load error irq", 32'h1, irq);
      clr();
   endtask

   task t_depth;
      fq.delete();
      repeat (191) fq.push_back(8'h00);
      fq.push_back(8'h10);
      load_form();
      chk("full form sense", 32'h0, rd & 32'hff00);
      fq.insert(0, 8'h00);
      load_form();
      // Entry 193 is cut off, so its end-of-form flag is lost too
      chk("overlong form", 32'hc00, rd & 32'hff00);
      clr();
   endtask

   task t_index;
      fq = '{8'h80, 8'h24, 8'h10};
      load_form();
      chk("indexed load sense", 32'h0, rd & 32'hff00);
      chk("eight lines", 32'h1, density_8lpi);
      cmd(`LPFC_C_SKIP, 4'h4);
      apb(1'b0, `LPFC_A_STAT, 32'h0);
      chk("indexed skip position", 32'h0, rd[15:8]);
   endtask

   task t_form;
      fq.delete();
      for (int i = 1; i < 12; i++)
         fq.push_back(8'(i));
      fq.push_back(8'h10);
      load_form();
      chk("six lines", 32'h0, density_8lpi);
      cmd(`LPFC_C_SPACE, 4'h3);
      apb(1'b0, `LPFC_A_STAT, 32'h0);
      chk("space position", 32'h3, rd[15:8]);
      lag <= 8'h14;
      cmd(`LPFC_C_SPACE, 4'h9);
      apb(1'b0, `LPFC_A_STAT, 32'h0);
      chk("end of form wrap", 32'h0, rd[15:8]);
      chk("done masked", 32'h0, irq);
      apb(1'b1, `LPFC_A_IRQM, 32'hb);
      repeat (2) @(posedge sys_clk);
      chk("done raised", 32'h1, irq);
      apb(1'b1, `LPFC_A_IRQS, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk("done cleared", 32'h0, irq);
      apb(1'b1, `LPFC_A_IRQM, 32'ha);
      lag <= 8'h00;
      for (int i = 1; i < 12; i++) begin
         cmd(`LPFC_C_SKIP, 4'(i));
         apb(1'b0, `LPFC_A_STAT, 32'h0);
         chk("skip position", i - 1, rd[15:8]);
      end
      steps = 0;
      cmd(`LPFC_C_SKIP, 4'hc);
      chk("runaway steps", 32'd14, steps);
      apb(1'b0, `LPFC_A_SNS_LO, 32'h0);
      chk("runaway sense", 32'h10, rd & 32'hff);
      apb(1'b0, `LPFC_A_IRQS, 32'h0);
      chk("runaway irq", 32'h1, rd[`LPFC_I_RUNAWAY]);
      clr();
   endtask

   task t_reject(input logic [3:0] c, input logic [3:0] arg);
      cmd(c, arg);
      apb(1'b0, `LPFC_A_SNS_LO, 32'h0);
      chk("command reject", 32'h80, rd & 32'hff);
      clr();
   endtask

   task t_print;
      for (int i = 0; i < 132; i++)
         apb(1'b1, `LPFC_A_PRINT, 32'h100);
      apb(1'b0, `LPFC_A_SNS_LO, 32'h0);
      chk("full line", 32'h0, rd[8 + `LPFC_S1_LINEOVF]);
      apb(1'b1, `LPFC_A_PRINT, 32'h100);
      apb(1'b0, `LPFC_A_SNS_LO, 32'h0);
      chk("line overflow", 32'h1, rd[8 + `LPFC_S1_LINEOVF]);
      clr();
      strobes = 0;
      cmd(`LPFC_C_PRINT, 4'h0);
      chk("print strobe", 32'h1, strobes);
      apb(1'b1, `LPFC_A_PRINT, 32'h000);
      repeat (2) @(posedge sys_clk);
      chk("motion inhibit", 32'h1, motion_inhibit);
      apb(1'b0, `LPFC_A_SNS_LO, 32'h0);
      chk("data check", 32'h1, rd[`LPFC_S0_DATACHK]);
      steps = 0;
      cmd(`LPFC_C_SPACE, 4'h2);
      chk("no motion", 32'h0, steps);
      chk("check irq", 32'h1, irq);
      clr();
      chk("inhibit released", 32'h0, motion_inhibit);
   endtask

   initial begin
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      t_regs();
      t_loaderr(8'h01, 8'h02, 8 + `LPFC_S1_NOEOF);
      t_loaderr(8'h0d, 8'h11, 8 + `LPFC_S1_BADCODE);
      t_loaderr(8'h41, 8'h11, 8 + `LPFC_S1_BADCODE);
      t_depth();
      t_index();
      t_form();
      t_reject(`LPFC_C_INDEX, 4'h0);
      t_reject(`LPFC_C_SKIP, 4'hd);
      t_print();
      conclude();
   end

   // Whole run needs well under a millisecond
   initial begin
      #1000000;
      err_count++;
      conclude();
   end
endmodule // lpfc_top_tb_top
`default_nettype wire
